// file: design/fcd_divider.sv
// Prescaler and reloading divider that make the timing clock enable
`include "fcd_cfg.svh"
module fcd_divider
(
    input logic core_clk,
    input logic reset,
    input logic run,
    input logic prescale_by_eight,
    input logic [5:0] ratio,
    output logic tick
);
    import fcd_pkg::*;

    typedef struct packed {
        logic [2:0] pre;
        logic [5:0] cnt;
        logic tick;
        logic armed;
    } fcd_div_state_t;

    fcd_div_state_t state_reg;
    fcd_div_state_t state_next;
    logic in_en;

    always_comb
    begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        in_en = prescale_by_eight ? (state_reg.pre == `FCD_PRESCALE_LAST) : 1'b1; // R4
        state_next.pre = state_reg.pre + 3'h1;
        state_next.armed = run && !reset;
        // Reload one cycle after run rises, so the new ratio is taken
        if (reset || !run || !state_reg.armed)
        begin
            state_next.pre = 3'h0;
            state_next.cnt = ratio;
        end
        else if (in_en)
        begin
            if (state_reg.cnt == 6'h00)
            begin
                state_next.cnt = ratio; // R20
                state_next.tick = 1'b1; // R5
            end
            else
            begin
                state_next.cnt = state_reg.cnt - 6'h01;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_reg <= state_next;
    end

    assign tick = state_reg.tick;

    logic [9:0] gap_reg;
    logic seen_reg;
    logic [9:0] period;
    assign period = prescale_by_eight ? {1'b0, ratio, 3'h0} + 10'h008 : {4'h0, ratio} + 10'h001;

    always_ff @(posedge core_clk)
    begin
        if (reset || !run)
        begin
            gap_reg <= 10'h000;
            seen_reg <= 1'b0;
        end
        else
        begin
            gap_reg <= tick ? 10'h001 : gap_reg + 10'h001;
            seen_reg <= seen_reg | tick;
        end
    end

    tick_period_a: assert property (@(posedge core_clk) disable iff (reset) // R5
        (run && seen_reg && tick) |-> gap_reg == period)
        else $error("timing tick spacing differs from divider period");
endmodule

// file: design/fcd_keycheck.sv
// Backdoor key comparator for eight ascending key writes
`include "fcd_cfg.svh"
module fcd_keycheck
(
    input logic core_clk,
    input logic reset,
    input logic arm,
    input logic byte_wr,
    input logic [7:0] byte_data,
    input logic [63:0] backdoor_key_bytes,
    input logic finish,
    output logic unlock
);
    import fcd_pkg::*;

    typedef struct packed {
        logic [3:0] idx;
        logic ok;
        logic unlock;
    } fcd_key_state_t;

    fcd_key_state_t state_reg;
    fcd_key_state_t state_next;
    logic [7:0] expect_byte;

    assign expect_byte = backdoor_key_bytes[{state_reg.idx[2:0], 3'h0} +: 8];

    always_comb
    begin
        state_next = state_reg;
        state_next.unlock = 1'b0;
        if (reset)
        begin
            state_next = '0;
        end
        else if (arm)
        begin
            state_next.idx = 4'h0;
            state_next.ok = 1'b1;
        end
        else if (finish)
        begin
            state_next.unlock = state_reg.ok && (state_reg.idx == `FCD_KEY_BYTES); // R14
            state_next.idx = 4'h0;
            state_next.ok = 1'b0;
        end
        else if (byte_wr)
        begin
            if (state_reg.idx == `FCD_KEY_BYTES)
            begin
                state_next.ok = 1'b0;
            end
            else
            begin
                state_next.ok = state_reg.ok && (byte_data == expect_byte); // R14
                state_next.idx = state_reg.idx + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_reg <= state_next;
    end

    assign unlock = state_reg.unlock;

    key_full_match_a: assert property (@(posedge core_clk) disable iff (reset) // R14
        unlock |-> ($past(state_reg.idx) == `FCD_KEY_BYTES) && $past(state_reg.ok))
        else $error("key unlock without eight matching bytes");
endmodule

// file: design/fcd_top.sv
// Write-once timing divider, option shadow, security and memory gate with APB registers
//
// Our own choices: the APB slave port and the register offsets.
`include "fcd_cfg.svh"
module fcd_top
(
    input logic core_clk,
    input logic reset,
    input fcd_pkg::fcd_apb_req_t apb_req,
    output fcd_pkg::fcd_apb_rsp_t apb_rsp,
    input logic debug_access,
    input logic [7:0] option_nv_byte,
    input logic [63:0] backdoor_key_bytes,
    input logic blank_ok,
    input logic op_start,
    input logic [7:0] op_pulses,
    output logic op_refused,
    output logic op_done,
    output logic prog_pulse,
    output logic nvm_timing_tick,
    output logic secured,
    output logic vector_redirect_en,
    input fcd_pkg::fcd_mem_req_t mem_req,
    output logic mem_grant,
    output logic mem_blocked,
    output logic [7:0] mem_rdata
);
    import fcd_pkg::*;

    typedef struct packed {
        fcd_ratio_t ratio;
        fcd_option_t option;
        logic secured;
        logic redirect_en;
        logic key_access;
        logic refused_seen;
        fcd_apb_rsp_t rsp;
        fcd_op_state_t op_state;
        logic [7:0] op_left;
        logic prog_pulse;
        logic op_refused;
        logic op_done;
        logic mem_grant;
        logic mem_blocked;
        logic [7:0] mem_rdata;
    } fcd_top_state_t;

    fcd_top_state_t state_reg;
    fcd_top_state_t state_next;
    logic tick;
    logic key_unlock;
    logic access;
    logic wr_done;
    logic wr_ratio;
    logic key_arm;
    logic key_finish;
    logic key_byte_wr;
    logic blocked;

    fcd_divider u_divider
    (
        .core_clk(core_clk),
        .reset(reset),
        .run(state_reg.ratio.loaded),
        .prescale_by_eight(state_reg.ratio.prescale_by_eight),
        .ratio(state_reg.ratio.ratio),
        .tick(tick)
    );

    fcd_keycheck u_keycheck
    (
        .core_clk(core_clk),
        .reset(reset),
        .arm(key_arm),
        .byte_wr(key_byte_wr),
        .byte_data(apb_req.pwdata[7:0]),
        .backdoor_key_bytes(backdoor_key_bytes),
        .finish(key_finish),
        .unlock(key_unlock)
    );

    assign access = apb_req.psel && apb_req.penable;
    assign wr_done = access && state_reg.rsp.pready && apb_req.pwrite;
    assign wr_ratio = wr_done && (apb_req.paddr == `FCD_OFS_RATIO);
    // Key control and data from debug commands are ignored
    assign key_arm = wr_done && !debug_access && (apb_req.paddr == `FCD_OFS_KEY_CTRL)
        && apb_req.pwdata[`FCD_KEY_ACCESS_BIT] && !state_reg.key_access; // R13
    assign key_finish = wr_done && !debug_access && (apb_req.paddr == `FCD_OFS_KEY_CTRL)
        && !apb_req.pwdata[`FCD_KEY_ACCESS_BIT] && state_reg.key_access; // R13
    assign key_byte_wr = wr_done && !debug_access && state_reg.key_access
        && (apb_req.paddr == `FCD_OFS_KEY_DATA); // R13
    assign blocked = state_reg.secured && (mem_req.from_debug || !mem_req.from_secure); // R18

    always_comb
    begin
        state_next = state_reg;
        state_next.rsp.pready = 1'b0;
        state_next.rsp.pslverr = 1'b0;
        state_next.op_refused = 1'b0;
        state_next.op_done = 1'b0;
        if (reset)
        begin
            state_next = '0;
            state_next.ratio = `FCD_RATIO_RESET; // R1
            state_next.option.backdoor_enable = option_nv_byte[`FCD_OPT_BACKDOOR_BIT]; // R9
            state_next.option.redirect_off = option_nv_byte[`FCD_OPT_REDIRECT_BIT]; // R9
            state_next.option.unused = 4'h0; // R10
            state_next.option.security_code = option_nv_byte[1:0]; // R9
            state_next.op_state = FCD_OP_IDLE;
        end
        else
        begin
            if (access && !state_reg.rsp.pready)
            begin
                state_next.rsp.pready = 1'b1;
                state_next.rsp.prdata = 32'h0000_0000;
                unique case (apb_req.paddr)
                    `FCD_OFS_RATIO:
                    begin
                        state_next.rsp.prdata = {24'h00_0000, state_reg.ratio};
                    end
                    `FCD_OFS_OPTION: // R11
                    begin
                        state_next.rsp.prdata = {24'h00_0000, state_reg.option.backdoor_enable,
                            state_reg.option.redirect_off, 4'h0,
                            state_reg.option.security_code}; // R10
                    end
                    `FCD_OFS_KEY_CTRL:
                    begin
                        state_next.rsp.prdata = {31'h0000_0000, state_reg.key_access};
                    end
                    `FCD_OFS_KEY_DATA:
                    begin
                        state_next.rsp.prdata = 32'h0000_0000;
                    end
                    `FCD_OFS_STATUS:
                    begin
                        state_next.rsp.prdata = {29'h0000_0000, state_reg.refused_seen,
                            state_reg.prog_pulse, state_reg.secured};
                    end
                    default:
                    begin
                        state_next.rsp.pslverr = 1'b1;
                    end
                endcase
            end
            if (wr_ratio && !state_reg.ratio.loaded)
            begin
                state_next.ratio.loaded = 1'b1; // R1
                state_next.ratio.prescale_by_eight =
                    apb_req.pwdata[`FCD_RATIO_PRESCALE_BIT]; // R2
                state_next.ratio.ratio = apb_req.pwdata[5:0]; // R2
            end
            if (key_arm || key_finish)
            begin
                state_next.key_access = key_arm;
            end
            if (wr_done && (apb_req.paddr == `FCD_OFS_STATUS)
                && apb_req.pwdata[`FCD_STAT_REFUSED_BIT])
            begin
                state_next.refused_seen = 1'b0;
            end
            if ((key_unlock && state_reg.option.backdoor_enable) || blank_ok) // R12
            begin
                state_next.option.security_code = `FCD_SEC_UNSECURED; // R17
            end
            unique case (state_reg.op_state)
                FCD_OP_IDLE:
                begin
                    if (op_start)
                    begin
                        if (!state_reg.ratio.loaded || op_pulses == 8'h00) // R3
                        begin
                            state_next.op_refused = 1'b1;
                            state_next.refused_seen = 1'b1;
                        end
                        else
                        begin
                            state_next.op_left = op_pulses;
                            state_next.op_state = FCD_OP_WAIT;
                        end
                    end
                end
                FCD_OP_WAIT:
                begin
                    if (op_start)
                    begin
                        state_next.op_refused = 1'b1;
                        state_next.refused_seen = 1'b1;
                    end
                    if (tick)
                    begin
                        state_next.prog_pulse = 1'b1; // R6
                        state_next.op_state = FCD_OP_PULSE;
                    end
                end
                FCD_OP_PULSE:
                begin
                    if (op_start)
                    begin
                        state_next.op_refused = 1'b1;
                        state_next.refused_seen = 1'b1;
                    end
                    if (tick)
                    begin
                        if (state_reg.op_left == 8'h01)
                        begin
                            state_next.prog_pulse = 1'b0; // R6
                            state_next.op_done = 1'b1;
                            state_next.op_state = FCD_OP_IDLE;
                        end
                        else
                        begin
                            state_next.op_left = state_reg.op_left - 8'h01;
                        end
                    end
                end
            endcase
            state_next.mem_grant = mem_req.req && !blocked; // R18
            state_next.mem_blocked = mem_req.req && blocked;
            state_next.mem_rdata = (mem_req.req && !blocked) ? mem_req.rdata : 8'h00; // R19
        end
        state_next.secured = state_next.option.security_code != `FCD_SEC_UNSECURED; // R16
        state_next.redirect_en = !state_next.option.redirect_off; // R15
    end

    always_ff @(posedge core_clk)
    begin
        state_reg <= state_next;
    end

    assign apb_rsp = state_reg.rsp;
    assign op_refused = state_reg.op_refused;
    assign op_done = state_reg.op_done;
    assign prog_pulse = state_reg.prog_pulse;
    assign nvm_timing_tick = tick;
    assign secured = state_reg.secured;
    assign vector_redirect_en = state_reg.redirect_en;
    assign mem_grant = state_reg.mem_grant;
    assign mem_blocked = state_reg.mem_blocked;
    assign mem_rdata = state_reg.mem_rdata;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence ratio_write_s;
        state_reg.ratio.loaded && wr_ratio;
    endsequence

    sequence pulse_edge_s;
        $changed(state_reg.prog_pulse);
    endsequence

    loaded_set_a: assert property (wr_ratio |=> state_reg.ratio.loaded) // R1
        else $error("loaded flag not set after ratio write");

    ratio_once_a: assert property (ratio_write_s |=> $stable(state_reg.ratio)) // R2
        else $error("ratio changed after first write");

    refuse_unloaded_a: assert property ((op_start && !state_reg.ratio.loaded) // R3
        |=> op_refused ##1 !prog_pulse [*3])
        else $error("operation accepted before ratio loaded");

    option_read_a: assert property ((access && !state_reg.rsp.pready // R10
        && apb_req.paddr == `FCD_OFS_OPTION) |=> apb_rsp.prdata[5:2] == 4'h0)
        else $error("unused option bits read nonzero");

    option_ro_a: assert property (##1 $stable({state_reg.option.backdoor_enable, // R11
        state_reg.option.redirect_off}))
        else $error("option bits changed without reset");

    unsecure_code_a: assert property (secured == // R16
        (state_reg.option.security_code != `FCD_SEC_UNSECURED))
        else $error("secured output disagrees with code");

    blank_unlock_a: assert property (blank_ok |=> !secured [*2]) // R17
        else $error("blank check did not unsecure");

    backdoor_enable_gate_a: assert property ((secured && !state_reg.option.backdoor_enable // R12
        && !blank_ok) |=> secured)
        else $error("unlocked while backdoor disabled");

    blocked_read_a: assert property ((mem_req.req && secured && mem_req.from_debug) // R19
        |=> !mem_grant && mem_blocked && mem_rdata == 8'h00)
        else $error("debug access reached secure memory");

    redirect_out_a: assert property (vector_redirect_en == // R15
        !state_reg.option.redirect_off)
        else $error("redirect output disagrees with option");

    pulse_whole_a: assert property (pulse_edge_s |-> $past(tick)) // R6
        else $error("timing pulse edge off the timing clock");

    pulse_end_done_a: assert property ($fell(prog_pulse) |-> op_done) // R6
        else $error("pulse ended without done");
endmodule

// file: dv/fcd_sw_model.sv
// Software-side APB master model for the divider and option registers
module fcd_sw_model
(
    input logic core_clk,
    input fcd_pkg::fcd_apb_rsp_t apb_rsp,
    output fcd_pkg::fcd_apb_req_t apb_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import fcd_pkg::*;

    // Prescale on, ratio 62: 100 MHz / 8 / 63 lands inside the timing band
    localparam logic [31:0] RATIO_WORD = 32'h0000_007e;

    initial apb_req = '0;

    // One transfer, request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        rdata = '0;
        err = 1'b1;
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        @(posedge core_clk);
        while (apb_rsp.pready !== 1'b1)
            @(posedge core_clk);
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    // Divider setup, issued after the refused request and before the accepted erase or program request
    task automatic load_ratio();
        logic [31:0] rd;
        logic er;
        xfer(1'b1, 8'h00, RATIO_WORD, rd, er);
    endtask
endmodule

// file: dv/fcd_top_test.sv
// Self-checking bench for the divider, option shadow and security gate
module fcd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fcd_pkg::*;

    localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic debug_access = 1'b0;
    logic blank_ok = 1'b0;
    logic op_start = 1'b0;
    logic [7:0] option_nv_byte = 8'hbf;
    logic [7:0] op_pulses = 8'h02;
    logic [63:0] backdoor_key_bytes = KEY;
    fcd_apb_req_t apb_req;
    fcd_apb_rsp_t apb_rsp;
    fcd_mem_req_t mem_req = '0;
    logic op_refused, op_done, prog_pulse, nvm_timing_tick, secured, vector_redirect_en;
    logic mem_grant, mem_blocked;
    logic [7:0] mem_rdata;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int last_tick = 0;
    int tick_gap = 0;
    int pulse_len = 0;
    int n_refused = 0;
    int n_done = 0;

    always #5 core_clk = ~core_clk;

    fcd_top u_dut (.core_clk(core_clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .debug_access(debug_access), .option_nv_byte(option_nv_byte),
        .backdoor_key_bytes(backdoor_key_bytes), .blank_ok(blank_ok), .op_start(op_start),
        .op_pulses(op_pulses), .op_refused(op_refused), .op_done(op_done),
        .prog_pulse(prog_pulse), .nvm_timing_tick(nvm_timing_tick), .secured(secured),
        .vector_redirect_en(vector_redirect_en), .mem_req(mem_req), .mem_grant(mem_grant),
        .mem_blocked(mem_blocked), .mem_rdata(mem_rdata));

    fcd_sw_model u_sw (.core_clk(core_clk), .apb_rsp(apb_rsp), .apb_req(apb_req));

    // Tick spacing, pulse length and pulse counters
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (nvm_timing_tick === 1'b1)
        begin
            tick_gap <= cyc - last_tick;
            last_tick <= cyc;
        end
        if (prog_pulse === 1'b1)
            pulse_len <= pulse_len + 1;
        else if (op_start === 1'b1)
            pulse_len <= 0;
        n_refused <= n_refused + int'(op_refused === 1'b1);
        n_done <= n_done + int'(op_done === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        u_sw.xfer(1'b0, addr, 32'h0, rd, er);
        check(rd, exp);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        u_sw.xfer(1'b1, addr, data, rd, er);
    endtask

    task automatic do_reset(input logic [7:0] nv);
        option_nv_byte <= nv;
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic pulse_op();
        @(posedge core_clk);
        op_start <= 1'b1;
        @(posedge core_clk);
        op_start <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic mem_chk(input logic sec, input logic dbg, input logic [9:0] exp);
        @(posedge core_clk);
        mem_req <= '{req: 1'b1, from_secure: sec, from_debug: dbg, rdata: 8'h5a};
        repeat (2) @(posedge core_clk);
        check({22'h0, mem_grant, mem_blocked, mem_rdata}, {22'h0, exp});
        mem_req <= '0;
    endtask

    task automatic enter_key(input logic dbg, input logic [63:0] key);
        debug_access <= dbg;
        wr(8'h08, 32'h1);
        for (int i = 0; i < 8; i++)
            wr(8'h0c, {24'h0, key[8*i +: 8]});
        wr(8'h08, 32'h0);
        debug_access <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_options();
        do_reset(8'hbf);
        rd_chk(8'h04, 32'h83);
        check(vector_redirect_en, 1'b1);
        check(secured, 1'b1);
        wr(8'h04, 32'h0);
        rd_chk(8'h04, 32'h83);
        rd_chk(8'h14, 32'h0);
        check(er, 1'b1);
    endtask

    task automatic t_refuse_and_gate();
        int r0;
        r0 = n_refused;
        pulse_op();
        check(n_refused - r0, 1);
        rd_chk(8'h10, 32'h5);
        wr(8'h10, 32'h4);
        rd_chk(8'h10, 32'h1);
        mem_chk(1'b0, 1'b1, {2'b01, 8'h00});
        mem_chk(1'b1, 1'b0, {2'b10, 8'h5a});
    endtask

    task automatic t_divider_op();
        int r0;
        int d0;
        u_sw.load_ratio();
        rd_chk(8'h00, 32'hfe);
        wr(8'h00, 32'h05);
        rd_chk(8'h00, 32'hfe);
        repeat (1600) @(posedge core_clk);
        check(tick_gap, 8 * 63);
        r0 = n_refused;
        d0 = n_done;
        pulse_op();
        repeat (700) @(posedge core_clk);
        pulse_op();
        for (int i = 0; i < 3000 && n_done == d0; i++)
            @(posedge core_clk);
        check(n_done - d0, 1);
        check(pulse_len, 2 * 8 * 63);
        check(n_refused - r0, 1);
        op_pulses <= 8'h00;
        pulse_op();
        check(n_refused - r0, 2);
    endtask

    task automatic t_security();
        enter_key(1'b1, KEY);
        check(secured, 1'b1);
        enter_key(1'b0, KEY ^ 64'h1);
        check(secured, 1'b1);
        enter_key(1'b0, KEY);
        check(secured, 1'b0);
        rd_chk(8'h04, 32'h82);
        mem_chk(1'b0, 1'b1, {2'b10, 8'h5a});
        do_reset(8'h7f);
        rd_chk(8'h04, 32'h43);
        check(vector_redirect_en, 1'b0);
        enter_key(1'b0, KEY);
        check(secured, 1'b1);
        @(posedge core_clk);
        blank_ok <= 1'b1;
        @(posedge core_clk);
        blank_ok <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(secured, 1'b0);
        do_reset(8'h3f);
        check(secured, 1'b1);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        t_options();
        t_refuse_and_gate();
        t_divider_op();
        t_security();
        stop_test();
    end

    initial
    begin
        #300us;
        err_total++;
        stop_test();
    end
endmodule

// file: include/fcd_cfg.svh
// Offsets, field positions, reset values and timing counts of the divider and option block
// Behaviour
// R1 - Loaded flag cleared at reset, set by write
// R2 - Ratio bits accept only first write after reset
// R3 - Erase and program refused until ratio loaded
// R4 - Prescale bit selects bus clock over eight
// R5 - Divider divides selected input by ratio plus one
// R6 - Timing pulses last whole timing clock periods
// R7 - Software keeps timing clock 150 to 200 kHz
// R8 - Software writes ratio before any erase/program
// R9 - Option byte copied from nonvolatile store at reset
// R10 - Option bits five to two read zero
// R11 - Option register readable, writes have no effect
// R12 - Backdoor enable zero blocks key unlocking
// R13 - Key writes from debug commands never unlock
// R14 - Eight matching ascending key bytes unlock until reset
// R15 - Redirect-off bit one disables vector redirection
// R16 - Security code binary 10 alone means unsecured
// R17 - Key unlock or blank check sets code 10
// R18 - Secured: unsecured sources cannot reach memory
// R19 - Blocked writes dropped, blocked reads give zero
// R20 - Divider counter reloads ratio at terminal count
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH

`define FCD_OFS_RATIO 8'h00
`define FCD_OFS_OPTION 8'h04
`define FCD_OFS_KEY_CTRL 8'h08
`define FCD_OFS_KEY_DATA 8'h0c
`define FCD_OFS_STATUS 8'h10

`define FCD_RATIO_LOADED_BIT 7
`define FCD_RATIO_PRESCALE_BIT 6
`define FCD_OPT_BACKDOOR_BIT 7
`define FCD_OPT_REDIRECT_BIT 6
`define FCD_KEY_ACCESS_BIT 0
`define FCD_STAT_SECURED_BIT 0
`define FCD_STAT_BUSY_BIT 1
`define FCD_STAT_REFUSED_BIT 2

`define FCD_RATIO_RESET 8'h00
`define FCD_SEC_UNSECURED 2'h2
`define FCD_PRESCALE_LAST 3'h7
`define FCD_KEY_BYTES 4'h8

`define FCD_CORE_HZ 100000000
`define FCD_NVM_CLK_MAX_HZ 200000
`define FCD_NVM_CLK_MIN_HZ 150000
`define FCD_NVM_MIN_PERIOD_CYC ((`FCD_CORE_HZ + `FCD_NVM_CLK_MAX_HZ - 1) / `FCD_NVM_CLK_MAX_HZ)
`define FCD_NVM_MAX_PERIOD_CYC (`FCD_CORE_HZ / `FCD_NVM_CLK_MIN_HZ)

`endif

// file: include/fcd_pkg.sv
// Types shared by the divider and option block
package fcd_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fcd_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fcd_apb_rsp_t;

    typedef struct packed {
        logic loaded;
        logic prescale_by_eight;
        logic [5:0] ratio;
    } fcd_ratio_t;

    typedef struct packed {
        logic backdoor_enable;
        logic redirect_off;
        logic [3:0] unused;
        logic [1:0] security_code;
    } fcd_option_t;

    typedef struct packed {
        logic req;
        logic from_secure;
        logic from_debug;
        logic [7:0] rdata;
    } fcd_mem_req_t;

    typedef enum logic [2:0] {
        FCD_OP_IDLE = 3'b001,
        FCD_OP_WAIT = 3'b010,
        FCD_OP_PULSE = 3'b100
    } fcd_op_state_t;
endpackage
